// *** include/sbyc_cfg.svh ***
// Register map, field positions and key values of the standby entry control
// Overview of operation
// - Key A503h sets both unlock bits
// - Low-power unlock allows standby and module-stop writes
// - Key A500h clears both unlock bits
// - Wait with standby-select one enters standby
// - Clearing oscillation-stop enable disables detection, needs unlock
// - Wait with standby-select zero enters sleep
`ifndef SBYC_CFG_SVH
`define SBYC_CFG_SVH
`define SBYC_OFS_PROTECT 8'h00
`define SBYC_OFS_STANDBY 8'h04
`define SBYC_OFS_MSTOP 8'h08
`define SBYC_OFS_OSTD 8'h0C
`define SBYC_OFS_DMA_START_REG 8'h10
`define SBYC_OFS_XFER 8'h14
`define SBYC_OFS_STATUS 8'h18
`define SBYC_KEY_HI 8'hA5
`define SBYC_KEY_LOCK 16'hA500
`define SBYC_KEY_ALL 16'hA503
`define SBYC_BIT_CG 0
`define SBYC_BIT_LP 1
`define SBYC_BIT_STANDBY_SELECT_BIT 15
`define SBYC_MSTOP_RST 32'h4FFF_FFFF
`define SBYC_MSTOP_ALL 31
`define SBYC_STANDBY_RST 16'h4000
`define SBYC_HSIZE_WORD 3'h2
`endif

// *** include/sbyc_pkg.sv ***
// Types shared by the standby entry control
package sbyc_pkg;
  typedef enum logic [1:0] {
    SBYC_RUN,
    SBYC_SLEEP,
    SBYC_STANDBY
  } sbyc_mode_type;
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic active;
  } sbyc_req_type;
endpackage

// *** logic/sbyc_top.sv ***
// AHB-Lite register block guarding software standby entry
`timescale 1ns/1ps
`default_nettype none
`include "sbyc_cfg.svh"
module sbyc_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire logic wait_exec_i,
  input wire logic wake_i,
  output logic sleep_o,
  output logic standby_o,
  output logic osc_stop_detect_enable_o,
  output logic dma_start_bit_o,
  output logic transfer_ctrl_start_bit_o,
  output logic [31:0] module_stop_o
);
  sbyc_pkg::sbyc_req_type req_q;
  sbyc_pkg::sbyc_mode_type mode_q;
  logic clockgen_unlock_bit_q;
  logic lowpower_unlock_bit_q;
  logic standby_select_bit_q;
  logic osd_en_q;
  logic dma_q;
  logic xfer_q;
  logic [31:0] mstop_q;
  logic [31:0] rdata_q;
  logic wr;
  logic [15:0] wd;
  logic key_hit;
  logic cg_view;
  logic lp_view;
  logic standby_select_bit_view;
  logic osd_view;
  logic dma_view;
  logic xfer_view;
  logic [31:0] mstop_view;

  // Protection model: the key register holds two unlock bits. The
  // low-power bit guards standby select and module stop; the clock
  // generation bit guards the oscillation-stop detector. A key write
  // whose upper byte is wrong is dropped whole, so a stray store cannot
  // clear protection by accident. The start bits of the transfer engines
  // are open to every write: software clears them itself before the
  // wait instruction, and the block does not police that order.
  // Mode: a wait in run goes to standby or sleep on the select bit; wake
  // returns to run and, seen together with wait, keeps the block running.

  // Zero-wait slave, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign wr = req_q.active && req_q.write;
  assign wd = hwdata_i[15:0];
  assign key_hit = wr && req_q.addr == `SBYC_OFS_PROTECT
                   && wd[15:8] == `SBYC_KEY_HI;

  // Values as they stand once the write now in its data phase lands. A
  // read whose address phase overlaps that write must see the new value,
  // so the read mux looks here rather than at the flops themselves.
  always_comb begin
    cg_view = clockgen_unlock_bit_q;
    lp_view = lowpower_unlock_bit_q;
    standby_select_bit_view = standby_select_bit_q;
    osd_view = osd_en_q;
    dma_view = dma_q;
    xfer_view = xfer_q;
    mstop_view = mstop_q;
    if (key_hit) begin
      cg_view = wd[`SBYC_BIT_CG];
      lp_view = wd[`SBYC_BIT_LP];
    end
    if (wr && lowpower_unlock_bit_q) begin
      if (req_q.addr == `SBYC_OFS_STANDBY) begin
        standby_select_bit_view = wd[`SBYC_BIT_STANDBY_SELECT_BIT];
      end
      if (req_q.addr == `SBYC_OFS_MSTOP) begin
        mstop_view = hwdata_i;
      end
    end
    if (wr && clockgen_unlock_bit_q && req_q.addr == `SBYC_OFS_OSTD) begin
      osd_view = hwdata_i[7];
    end
    if (wr && req_q.addr == `SBYC_OFS_DMA_START_REG) begin
      dma_view = hwdata_i[0];
    end
    if (wr && req_q.addr == `SBYC_OFS_XFER) begin
      xfer_view = hwdata_i[0];
    end
  end

  // Capture address phase; only whole-word writes are decoded, others
  // still complete OKAY but change nothing
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_q <= '0;
    end else if (hready_i) begin
      req_q.active <= hsel_i && htrans_i[1]
                      && hsize_i == `SBYC_HSIZE_WORD;
      req_q.write <= hwrite_i;
      req_q.addr <= haddr_i;
    end
  end

  // Key register; wrong upper byte leaves the unlock bits alone
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clockgen_unlock_bit_q <= 1'b0;
      lowpower_unlock_bit_q <= 1'b0;
    end else if (wr && req_q.addr == `SBYC_OFS_PROTECT
                 && wd[15:8] == `SBYC_KEY_HI) begin
      clockgen_unlock_bit_q <= wd[`SBYC_BIT_CG];
      lowpower_unlock_bit_q <= wd[`SBYC_BIT_LP];
    end
  end

  // Low-power registers accept writes only when unlocked
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      standby_select_bit_q <= 1'b0;
      mstop_q <= `SBYC_MSTOP_RST;
    end else if (wr && lowpower_unlock_bit_q) begin
      if (req_q.addr == `SBYC_OFS_STANDBY) begin
        standby_select_bit_q <= wd[`SBYC_BIT_STANDBY_SELECT_BIT];
      end
      if (req_q.addr == `SBYC_OFS_MSTOP) begin
        mstop_q <= hwdata_i;
      end
    end
  end

  // Oscillation-stop detector enable, clock-generation protected
  // A locked write is dropped silently; the bus still answers OKAY
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      osd_en_q <= 1'b0;
    end else if (wr && clockgen_unlock_bit_q
                 && req_q.addr == `SBYC_OFS_OSTD) begin
      osd_en_q <= hwdata_i[7];
    end
  end

  // Transfer engine start bits are unprotected
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dma_q <= 1'b0;
      xfer_q <= 1'b0;
    end else if (wr) begin
      if (req_q.addr == `SBYC_OFS_DMA_START_REG) begin
        dma_q <= hwdata_i[0];
      end
      if (req_q.addr == `SBYC_OFS_XFER) begin
        xfer_q <= hwdata_i[0];
      end
    end
  end

  // Mode on wait; a wake event returns to run and wins over wait
  // Wait is taken only in run; in sleep or standby it is ignored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= sbyc_pkg::SBYC_RUN;
    end else begin
      unique case (mode_q)
        sbyc_pkg::SBYC_RUN: begin
          if (wait_exec_i && !wake_i) begin
            mode_q <= standby_select_bit_q ? sbyc_pkg::SBYC_STANDBY
                                           : sbyc_pkg::SBYC_SLEEP;
          end
        end
        default: begin
          if (wake_i) begin
            mode_q <= sbyc_pkg::SBYC_RUN;
          end
        end
      endcase
    end
  end

  // Read data comes from a flop during the data phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (hready_i && hsel_i && htrans_i[1] && !hwrite_i) begin
      unique case (haddr_i)
        `SBYC_OFS_PROTECT: rdata_q <= {30'h0000_0000,
          lp_view, cg_view};
        `SBYC_OFS_STANDBY: rdata_q <= {16'h0000,
          standby_select_bit_view, 15'h4000};
        `SBYC_OFS_MSTOP: rdata_q <= mstop_view;
        `SBYC_OFS_OSTD: rdata_q <= {24'h00_0000, osd_view, 7'h00};
        `SBYC_OFS_DMA_START_REG: rdata_q <= {31'h0000_0000, dma_view};
        `SBYC_OFS_XFER: rdata_q <= {31'h0000_0000, xfer_view};
        `SBYC_OFS_STATUS: rdata_q <= {30'h0000_0000, mode_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // Level outputs straight from the flops
  assign hrdata_o = rdata_q;
  assign sleep_o = (mode_q == sbyc_pkg::SBYC_SLEEP);
  assign standby_o = (mode_q == sbyc_pkg::SBYC_STANDBY);
  assign osc_stop_detect_enable_o = osd_en_q;
  assign dma_start_bit_o = dma_q;
  assign transfer_ctrl_start_bit_o = xfer_q;
  assign module_stop_o = mstop_q;
endmodule
`default_nettype wire

// *** sim/sbyc_props.sv ***
// Port checks of the standby entry control
`timescale 1ns/1ps
`default_nettype none
module sbyc_props (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic hsel_i,
  input wire logic [7:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic wait_exec_i,
  input wire logic wake_i,
  input wire logic sleep_o,
  input wire logic standby_o,
  input wire logic osc_stop_detect_enable_o,
  input wire logic [31:0] module_stop_o
);
  logic w_q, cg_q, lp_q, sel_q;
  logic [7:0] a_q;
  wire logic ky = w_q && a_q == 8'h00;
  wire logic ms = w_q && a_q == 8'h08;
  wire logic os = w_q && a_q == 8'h0C;
  wire logic go = wait_exec_i && !wake_i && !sleep_o && !standby_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Shadow of the unlock and select bits, so a bad key byte is ignored
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {w_q, cg_q, lp_q, sel_q, a_q} <= '0;
    end else begin
      w_q <= hsel_i && hready_i && htrans_i[1] && hwrite_i;
      a_q <= haddr_i;
      if (ky && hwdata_i[15:8] == 8'hA5) {lp_q, cg_q} <= hwdata_i[1:0];
      if (w_q && a_q == 8'h04 && lp_q) sel_q <= hwdata_i[15];
    end
  end
  AST_KEY_OPEN: assert property (
    ky && hwdata_i[15:0] == 16'hA503 ##[1:4] ms
    |=> module_stop_o == $past(hwdata_i)) else $error("unlock failed");
  AST_LP_WR: assert property (ms && lp_q
    |=> module_stop_o == $past(hwdata_i)) else $error("write lost");
  AST_KEY_LOCK: assert property (
    ky && hwdata_i[15:0] == 16'hA500 ##[1:4] ms
    |=> $stable(module_stop_o)) else $error("lock failed");
  AST_STBY: assert property (go && sel_q
    |=> standby_o && !sleep_o) else $error("no standby");
  AST_OSC: assert property (os && cg_q
    |=> osc_stop_detect_enable_o == $past(hwdata_i[7])) else $error("osc");
  AST_SLEEP: assert property (go && !sel_q
    |=> sleep_o && !standby_o) else $error("no sleep");
  AST_GUARD: assert property (ms && !lp_q
    |=> $stable(module_stop_o)) else $error("locked write taken");
endmodule
bind sbyc_top sbyc_props u_props (.*);
`default_nettype wire

// *** sim/standby_entry_control_test.sv ***
// Register-level test of the standby entry control
`timescale 1ns/1ps
`default_nettype none
module standby_entry_control_test;
  logic clk_i, rst_n_i, hwrite_i, wait_exec_i, wake_i, hresp_o;
  logic hsel_i = 1'h1;
  logic [2:0] hsize_i = 3'h2;
  logic [7:0] haddr_i;
  logic [1:0] htrans_i;
  logic [31:0] hwdata_i, hrdata_o, module_stop_o, r;
  logic hreadyout_o, sleep_o, standby_o, osc_stop_detect_enable_o;
  logic dma_start_bit_o, transfer_ctrl_start_bit_o;
  wire logic hready_i = hreadyout_o;
  int err_total = 0;
  int tests_run = 0;
  sbyc_top dut (.*);
  task automatic finish_test;
    if (err_total == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  // Bounded wait for hready, a stuck slave ends the run
  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (hreadyout_o !== 1'h1 && n < 20);
    if (hreadyout_o !== 1'h1) begin
      err_total++;
      finish_test;
    end
  endtask
  task automatic xf(input logic [7:0] a, input logic w, input logic [31:0] d);
    haddr_i <= a;
    hwrite_i <= w;
    htrans_i <= 2'h2;
    rdy;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    rdy;
    r = hrdata_o;
    // One idle edge lets register outputs settle before they are compared
    @(posedge clk_i);
  endtask
  // Wait pulse, check pins and status, then wake back to run
  task automatic go(input logic [31:0] e, input logic [31:0] s);
    wait_exec_i <= 1'h1;
    @(posedge clk_i);
    wait_exec_i <= 1'h0;
    @(posedge clk_i);
    chk("mode", {30'h0, sleep_o, standby_o}, e);
    xf(8'h18, 1'h0, 32'h0);
    chk("stat", r, s);
    wake_i <= 1'h1;
    @(posedge clk_i);
    wake_i <= 1'h0;
    @(posedge clk_i);
    chk("run", {30'h0, sleep_o, standby_o}, 32'h0);
  endtask
  initial begin
    clk_i = 1'h0;
    forever #2.5 clk_i = ~clk_i;
  end
  // Entry sequence with locked, unlocked and relocked phases
  initial begin
    {rst_n_i, hwrite_i, wait_exec_i, wake_i, haddr_i, htrans_i} = '0;
    hwdata_i = 32'h0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'h1;
    @(posedge clk_i);
    xf(8'h10, 1'h1, 32'h1);
    xf(8'h14, 1'h1, 32'h1);
    chk("dma", {31'h0, dma_start_bit_o}, 32'h1);
    chk("dtc", {31'h0, transfer_ctrl_start_bit_o}, 32'h1);
    xf(8'h08, 1'h1, 32'h0);
    chk("mstp", module_stop_o, 32'h4FFF_FFFF);
    chk("resp", {31'h0, hresp_o}, 32'h0);
    xf(8'h0C, 1'h1, 32'h0000_0080);
    chk("osc", {31'h0, osc_stop_detect_enable_o}, 32'h0);
    xf(8'h00, 1'h1, 32'h0000_A503);
    xf(8'h08, 1'h1, 32'h1234_5678);
    chk("mstp", module_stop_o, 32'h1234_5678);
    xf(8'h0C, 1'h1, 32'h0000_0080);
    chk("osc", {31'h0, osc_stop_detect_enable_o}, 32'h1);
    xf(8'h04, 1'h1, 32'h0000_8000);
    xf(8'h04, 1'h0, 32'h0);
    chk("sby", r, 32'h0000_C000);
    xf(8'h0C, 1'h1, 32'h0000_0000);
    chk("osc", {31'h0, osc_stop_detect_enable_o}, 32'h0);
    xf(8'h00, 1'h1, 32'h0000_A500);
    xf(8'h08, 1'h1, 32'h0);
    chk("mstp", module_stop_o, 32'h1234_5678);
    xf(8'h10, 1'h1, 32'h0);
    xf(8'h14, 1'h1, 32'h0);
    chk("dma", {31'h0, dma_start_bit_o}, 32'h0);
    chk("dtc", {31'h0, transfer_ctrl_start_bit_o}, 32'h0);
    xf(8'h14, 1'h0, 32'h0);
    chk("dtcrd", r, 32'h0);
    go(32'h1, 32'h2);
    xf(8'h00, 1'h1, 32'h0000_A503);
    xf(8'h04, 1'h1, 32'h0);
    go(32'h2, 32'h1);
    finish_test;
  end
endmodule
`default_nettype wire
